// File: link_status_pkg.sv
// Constants and carriers for the link status response builder.
// Assumes one APB clock domain shared with the command and link logic.
package link_status_pkg;
  // ==========================================================
  // Packet codes and layout
  localparam logic [7:0]  CMD_GET_LINK  = 8'h0a;
  localparam logic [7:0]  RESP_GET_LINK = 8'h8a;
  localparam logic [7:0]  HDR_REV       = 8'h01;
  localparam logic [11:0] PAYLOAD_LEN   = 12'h010;
  localparam logic [5:0]  LAST_BYTE     = 6'h2d;
  localparam int          FRAME_BYTES   = 46;
  localparam int          B_MC_ID       = 0;
  localparam int          B_REV         = 1;
  localparam int          B_IID         = 3;
  localparam int          B_TYPE        = 4;
  localparam int          B_CHAN        = 5;
  localparam int          B_LEN         = 6;
  localparam int          B_RESP        = 16;
  localparam int          B_STATUS      = 20;
  localparam int          B_OTHER       = 24;
  localparam int          B_VENDOR      = 28;
  localparam int          B_CSUM        = 32;
  localparam int          B_PAD         = 36;
  // ==========================================================
  // Link status word fields
  localparam int          LS_LINK       = 0;
  localparam int          LS_SPEED      = 1;
  localparam int          LS_AN_EN      = 5;
  localparam int          LS_AN_DONE    = 6;
  localparam int          LS_EXT        = 24;
  localparam logic [3:0]  SPEED_NONE    = 4'h0;
  localparam logic [3:0]  SPEED_MAX_V10 = 4'h8;
  localparam logic [3:0]  SPEED_EXT     = 4'hf;
  // ==========================================================
  // Register map
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_CHAN      = 12'h004;
  localparam logic [11:0] OFF_STATUS    = 12'h008;
  localparam logic [11:0] OFF_COUNT     = 12'h00c;
  localparam int          CTRL_REV11    = 0;
  localparam int          CTRL_AN_SUP   = 1;
  localparam int          CTRL_FORCE    = 2;
  localparam int          CTRL_FCODE    = 4;
  localparam logic [7:0]  CTRL_RESET    = 8'h02;
  localparam logic [7:0]  CHAN_RESET    = 8'h00;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] mc_id;
    logic [7:0] hdr_rev;
    logic [7:0] iid;
    logic [7:0] cmd_type;
    logic [7:0] channel;
    logic       csum_ok;
  } query_s;
  typedef struct packed {
    logic        link_up;
    logic        an_enable;
    logic        an_complete;
    logic        serializer_link_indicator;
    logic        hcd_found;
    logic [3:0]  highest_common_mode;
    logic [7:0]  ext_speed;
    logic [31:0] other_ind;
    logic [31:0] vendor_link_word;
  } link_s;
endpackage

// File: link_status_response_builder.sv
// Builds the link status response frame and streams it out bytewise.
// Assumes query and link inputs come from logic on pclk; APB master on pclk.
// Operation
// - Accept each good query for this channel and answer with type 0x8A.
// - Header in bytes 0-15, response and reason codes in 16-19.
// - Status 20-23, other 24-27, vendor 28-31, checksum 32-35, pad 36-45.
// - Bit 0 is one while the link is up, zero when down.
// - Bits 4:1 hold the speed and duplex code, 1 through 8.
// - Codes 9-14 optional; reserved when running the first protocol revision.
// - Speed reads zero if negotiation incomplete, serializer set, or no common mode.
// - Code 15 points to the extended field starting at bit 24.
// - With serializer clear a forced link setting may be reported.
// - Unlisted media may report nearest listed code; no media implied.
// - Bit 5 is one only when auto-negotiation is supported and enabled.
// - Link flag always present; negotiation flag present when supported.
// - Bit 6 is one when negotiation completed, zero if unsupported or disabled.
//
// Local design decisions: the APB slave port and the register addresses.
module link_status_response_builder (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     query_valid,
  output logic                          query_ready,
  input  wire link_status_pkg::query_s  query,
  input  wire link_status_pkg::link_s   link,
  output logic                          tx_valid,
  input  wire logic                     tx_ready,
  output logic      [7:0]               tx_data,
  output logic                          tx_last
);
  // ==========================================================
  // Registers
  logic [7:0]        ctrl;
  logic [7:0]        chan_id;
  logic [15:0]       acc_count;
  logic [15:0]       drop_count;
  logic [31:0]       status_word;
  logic [3:0]        speed_code;
  logic [0:45][7:0]  frame_q;
  logic [0:45][7:0]  next_frame;
  logic [5:0]        idx;
  logic              take;
  logic              accept;
  logic              drop;
  logic              rev11;
  logic              an_sup;
  logic              an_on;
  logic              wr;
  logic              setup;
  logic              mapped;

  assign rev11  = ctrl[link_status_pkg::CTRL_REV11];
  assign an_sup = ctrl[link_status_pkg::CTRL_AN_SUP];
  assign an_on  = an_sup & link.an_enable;

  // ==========================================================
  // APB slave
  assign pready  = 1'b1;
  assign mapped  = (paddr == link_status_pkg::OFF_CTRL) ||
                   (paddr == link_status_pkg::OFF_CHAN) ||
                   (paddr == link_status_pkg::OFF_STATUS) ||
                   (paddr == link_status_pkg::OFF_COUNT);
  assign pslverr = psel & penable & ~mapped;
  assign wr      = psel & penable & pwrite & mapped;
  assign setup   = psel & ~penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= link_status_pkg::CTRL_RESET;
      chan_id <= link_status_pkg::CHAN_RESET;
    end else if (wr) begin
      if (paddr == link_status_pkg::OFF_CTRL) begin
        ctrl <= pwdata[7:0];
      end
      if (paddr == link_status_pkg::OFF_CHAN) begin
        chan_id <= pwdata[7:0];
      end
    end
  end

  // Read data prepared during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      unique case (paddr)
        link_status_pkg::OFF_CTRL:   prdata <= {24'h00_0000, ctrl};
        link_status_pkg::OFF_CHAN:   prdata <= {24'h00_0000, chan_id};
        link_status_pkg::OFF_STATUS: prdata <= status_word;
        link_status_pkg::OFF_COUNT:  prdata <= {drop_count, acc_count};
        default:                     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Link status word
  always_comb begin
    speed_code = link_status_pkg::SPEED_NONE;
    if (an_on) begin
      if (link.an_complete && link.hcd_found) begin
        speed_code = link.highest_common_mode;
      end
    end else if (ctrl[link_status_pkg::CTRL_FORCE]) begin
      speed_code = ctrl[link_status_pkg::CTRL_FCODE +: 4];
    end
    if (link.serializer_link_indicator) begin
      speed_code = link_status_pkg::SPEED_NONE;
    end
    if (!rev11 && speed_code > link_status_pkg::SPEED_MAX_V10) begin
      speed_code = link_status_pkg::SPEED_NONE;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[link_status_pkg::LS_LINK] = link.link_up;
    status_word[link_status_pkg::LS_SPEED +: 4] = speed_code;
    status_word[link_status_pkg::LS_AN_EN] = an_on;
    status_word[link_status_pkg::LS_AN_DONE] = an_on & link.an_complete;
    // Extended field only with code 15
    if (speed_code == link_status_pkg::SPEED_EXT) begin
      status_word[link_status_pkg::LS_EXT +: 8] = link.ext_speed;
    end
  end

  // ==========================================================
  // Query acceptance
  assign query_ready = ~tx_valid;
  assign take        = query_valid & query_ready;
  assign accept = take && query.csum_ok &&
                  (query.cmd_type == link_status_pkg::CMD_GET_LINK) &&
                  (query.channel == chan_id);
  assign drop   = take & ~accept;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_count  <= 16'h0000;
      drop_count <= 16'h0000;
    end else begin
      if (accept) begin
        acc_count <= acc_count + 16'h0001;
      end
      if (drop) begin
        drop_count <= drop_count + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Frame assembly
  always_comb begin
    logic [31:0] sum;
    logic [31:0] csum;
    sum = 32'h0000_0000;
    csum = 32'h0000_0000;
    next_frame = '0;
    next_frame[link_status_pkg::B_MC_ID] = query.mc_id;
    next_frame[link_status_pkg::B_REV]   = link_status_pkg::HDR_REV;
    next_frame[link_status_pkg::B_IID]   = query.iid;
    next_frame[link_status_pkg::B_TYPE]  = link_status_pkg::RESP_GET_LINK;
    next_frame[link_status_pkg::B_CHAN]  = chan_id;
    next_frame[link_status_pkg::B_LEN]   = {4'h0, link_status_pkg::PAYLOAD_LEN[11:8]};
    next_frame[link_status_pkg::B_LEN + 1] = link_status_pkg::PAYLOAD_LEN[7:0];
    for (int b = 0; b < 4; b++) begin
      next_frame[link_status_pkg::B_STATUS + b] = status_word[(3 - b) * 8 +: 8];
      next_frame[link_status_pkg::B_OTHER + b]  = link.other_ind[(3 - b) * 8 +: 8];
      next_frame[link_status_pkg::B_VENDOR + b] = link.vendor_link_word[(3 - b) * 8 +: 8];
    end
    for (int w = 0; w < link_status_pkg::B_CSUM / 2; w++) begin
      sum = sum + {16'h0000, next_frame[2 * w], next_frame[2 * w + 1]};
    end
    csum = 32'h0000_0000 - sum;
    for (int b = 0; b < 4; b++) begin
      next_frame[link_status_pkg::B_CSUM + b] = csum[(3 - b) * 8 +: 8];
    end
  end

  // ==========================================================
  // Byte stream out
  assign tx_last = tx_valid & (idx == link_status_pkg::LAST_BYTE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_q <= '0;
    end else if (accept) begin
      frame_q <= next_frame;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      idx      <= 6'h00;
      tx_data  <= 8'h00;
    end else if (accept) begin
      tx_valid <= 1'b1;
      idx      <= 6'h00;
      tx_data  <= next_frame[0];
    end else if (tx_valid && tx_ready) begin
      if (idx == link_status_pkg::LAST_BYTE) begin
        tx_valid <= 1'b0;
        tx_data  <= 8'h00;
      end else begin
        idx     <= idx + 6'h01;
        tx_data <= frame_q[idx + 6'h01];
      end
    end
  end

  // ==========================================================
  // Checks
  resp_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> tx_valid && idx == 6'h00 && frame_q[4] == 8'h8a)
    else $error("accepted query did not start a response");

  hdr_layout_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> frame_q[16] == 8'h00 && frame_q[19] == 8'h00 && frame_q[5] == $past(chan_id))
    else $error("header or codes misplaced");

  status_place_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> frame_q[23] == $past(status_word[7:0]) && frame_q[20] == $past(status_word[31:24]))
    else $error("status word misplaced");

  frame_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("frame did not end after last byte");

  pad_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && idx > 6'h23 |-> tx_data == 8'h00)
    else $error("pad byte not zero");

  link_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[0] == link.link_up)
    else $error("link flag wrong");

  speed_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    an_on && link.an_complete && link.hcd_found && !link.serializer_link_indicator &&
    link.highest_common_mode <= 4'h8 |-> status_word[4:1] == link.highest_common_mode)
    else $error("negotiated speed not reported");

  old_rev_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rev11 |-> status_word[4:1] <= 4'h8)
    else $error("reserved speed code under first revision");

  speed_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    link.serializer_link_indicator || (an_on && !link.an_complete) |-> status_word[4:1] == 4'h0)
    else $error("speed not zero while unresolved");

  an_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[5] == (an_sup && link.an_enable))
    else $error("negotiation flag wrong");

  an_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[6] |-> status_word[5] && link.an_complete)
    else $error("negotiation complete without enable");

  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[23:7] == 17'h0_0000 && (status_word[4:1] == 4'hf || status_word[31:24] == 8'h00))
    else $error("reserved status bits set");

  ext_field_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[4:1] == 4'hf |-> status_word[31:24] == link.ext_speed)
    else $error("extended speed field missing");

  forced_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    !an_on && ctrl[link_status_pkg::CTRL_FORCE] && rev11 && !link.serializer_link_indicator |->
    status_word[4:1] == ctrl[link_status_pkg::CTRL_FCODE +: 4])
    else $error("forced speed not reported");

  resp_codes_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> frame_q[17] == 8'h00 && frame_q[18] == 8'h00 && frame_q[3] == $past(query.iid))
    else $error("response codes or header wrong");

  other_place_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> frame_q[24] == $past(link.other_ind[31:24]) && frame_q[31] == $past(link.vendor_link_word[7:0]))
    else $error("other or vendor word misplaced");

  byte_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(idx))
    else $error("byte changed while stalled");

  an_unsup_a: assert property (@(posedge pclk) disable iff (!presetn)
    !an_sup |-> status_word[6:5] == 2'b00)
    else $error("negotiation flags set while unsupported");
endmodule

// File: link_status_mc_model.sv
// Management controller model: offers queries and collects frame bytes.
// Assumes the pclk domain; slow makes the byte handshake stall every other cycle.
module link_status_mc_model (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     slow,
  input  wire logic                     query_ready,
  input  wire logic                     tx_valid,
  input  wire logic [7:0]               tx_data,
  input  wire logic                     tx_last,
  output logic                          query_valid,
  output link_status_pkg::query_s       query,
  output logic                          tx_ready,
  output logic      [367:0]             frame,
  output logic      [6:0]               frame_len,
  output logic                          frame_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    query_valid = 1'b0;
    query = '0;
  end
  task automatic offer(input link_status_pkg::query_s q);
    @(posedge pclk);
    query_valid <= 1'b1;
    query <= q;
    @(negedge pclk);
    while (query_ready !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    query_valid <= 1'b0;
    query <= ~q;
  endtask
  // ==========================================================
  // Byte sink
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      frame <= '0;
      frame_len <= 7'd0;
      frame_done <= 1'b0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      frame_done <= 1'b0;
      if (frame_done) frame_len <= 7'd0;
      if (tx_valid && tx_ready) begin
        frame <= {frame[359:0], tx_data};
        frame_len <= frame_len + 7'd1;
        frame_done <= tx_last;
      end
    end
  end
endmodule

// File: link_status_response_builder_bench.sv
// Bench: APB master, query traffic through the model, queued frame checks.
// Assumes the package, the design and the controller model are compiled first.
`define CHK(n, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); \
  end \
end
module link_status_response_builder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
  logic                    query_valid, query_ready, tx_valid, tx_ready, tx_last, frame_done;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic [7:0]              tx_data;
  logic [6:0]              frame_len;
  logic [367:0]            frame;
  logic [15:0]             rnd;
  logic [367:0]            expq[$];
  link_status_pkg::query_s query;
  link_status_pkg::link_s  link;
  int                      errors, checks_done, acc, drop;
  link_status_response_builder uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .query_valid(query_valid), .query_ready(query_ready), .query(query), .link(link), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));
  link_status_mc_model mc (.pclk(pclk), .presetn(presetn), .slow(slow), .query_ready(query_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .query_valid(query_valid), .query(query),
    .tx_ready(tx_ready), .frame(frame), .frame_len(frame_len), .frame_done(frame_done));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [31:0] status(input logic [7:0] c, input link_status_pkg::link_s l);
    logic [3:0] code;
    logic       an;
    an = c[1] && l.an_enable;
    code = an ? ((l.an_complete && l.hcd_found) ? l.highest_common_mode : 4'h0) : (c[2] ? c[7:4] : 4'h0);
    if (l.serializer_link_indicator || (!c[0] && code > 4'h8)) code = 4'h0;
    status = {(code == 4'hf) ? l.ext_speed : 8'h00, 17'h0_0000, an && l.an_complete, an, code, l.link_up};
  endfunction
  function automatic logic [367:0] frm(input link_status_pkg::query_s q, input logic [7:0] c,
                                       input link_status_pkg::link_s l);
    logic [255:0] h;
    logic [31:0]  s;
    h = {q.mc_id, 8'h01, 8'h00, q.iid, 8'h8a, 8'h05, 16'h0010, 96'h0, status(c, l), l.other_ind,
         l.vendor_link_word};
    s = 32'h0000_0000;
    for (int i = 0; i < 16; i++) s = s - {16'h0000, h[255 - 16 * i -: 16]};
    frm = {h, s, 80'h0};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [7:0] c, input logic [4:0] f, input logic [3:0] m, input logic [1:0] bad);
    link_status_pkg::link_s  lv;
    link_status_pkg::query_s qv;
    rnd = lfsr(rnd);
    lv = {f, m, rnd[15:8], rnd, ~rnd, ~rnd, rnd};
    qv = {rnd[7:0], 8'h01, rnd[15:8], (bad == 2'd3) ? 8'h09 : 8'h0a, (bad == 2'd2) ? 8'h06 : 8'h05, bad != 2'd1};
    apb(1'b1, 12'h000, {24'h00_0000, c});
    link <= lv;
    apb(1'b0, 12'h008, 32'h0000_0000);
    `CHK("status word", status(c, lv), rd)
    if (bad == 2'd0) begin
      expq.push_back(frm(qv, c, lv));
      acc++;
    end else drop++;
    mc.offer(qv);
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Frame monitor
  always @(posedge pclk) begin : mon
    logic [367:0] e;
    if (frame_done === 1'b1) begin
      if (expq.size() == 0) begin
        errors++;
        $display("CHECK FAILED frame expected none seen %h", frame);
      end else begin
        e = expq.pop_front();
        `CHK("frame", e, frame)
        `CHK("frame length", 7'd46, frame_len)
      end
    end
  end
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_of_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, slow} = 5'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    link = '0;
    rnd = 16'h14f6;
    {errors, checks_done, acc, drop} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    `CHK("control reset", 32'h0000_0002, rd)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    `CHK("ready", 1'b1, pready)
    apb(1'b1, 12'h004, 32'h0000_0005);
    $display("Test registers done");
    for (int i = 0; i < 16; i++) run(8'h03, 5'b11101, i[3:0], 2'd0);
    $display("Test negotiated codes done");
    for (int i = 9; i < 16; i++) run(8'h02, 5'b11101, i[3:0], 2'd0);
    $display("Test reserved codes done");
    slow <= 1'b1;
    run(8'h03, 5'b11111, 4'h7, 2'd0);
    run(8'h03, 5'b11001, 4'h7, 2'd0);
    run(8'h03, 5'b11100, 4'h7, 2'd0);
    run(8'h03, 5'b01101, 4'h6, 2'd0);
    $display("Test zero speed done");
    for (int i = 0; i < 16; i++) run({i[3:0], 4'h7}, 5'b10000, 4'h3, 2'd0);
    run(8'h57, 5'b10010, 4'h3, 2'd0);
    run(8'h01, 5'b11101, 4'h7, 2'd0);
    $display("Test forced codes done");
    for (int i = 1; i < 4; i++) run(8'h03, 5'b11101, 4'h2, i[1:0]);
    while (expq.size() != 0) @(posedge pclk);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    `CHK("query counts", {drop[15:0], acc[15:0]}, rd)
    $display("Test dropped queries done");
    end_of_test();
  end
endmodule
